// File: verilog/mode_switch_pkg.sv
package mode_switch_pkg;
  // ==========================================================
  // Timing
  // ==========================================================
  localparam int CLK_MHZ          = 125;
  localparam int BLANK_NS         = 500;
  localparam int BLANK_CYC        = (BLANK_NS * CLK_MHZ + 999) / 1000;
  localparam int OFF_MIN_NS       = 1600;
  localparam int OFF_MIN_CYC      = (OFF_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int OFF_MAX_US       = 420;
  localparam int OFF_MAX_CYC      = OFF_MAX_US * CLK_MHZ;
  localparam int RETRY_MS         = 280;
  localparam int RETRY_CYC        = RETRY_MS * CLK_MHZ * 1000;
  localparam int SHORT_FREQ_HZ    = 2500;
  localparam int SHORT_PERIOD_CYC = CLK_MHZ * 1000000 / SHORT_FREQ_HZ;
  // ==========================================================
  // Mix level in mode 3, percent of full current
  // ==========================================================
  localparam logic [6:0] PCT_A0_B0 = 7'h41;
  localparam logic [6:0] PCT_A0_BN = 7'h64;
  localparam logic [6:0] PCT_AR_B0 = 7'h55;
  localparam logic [6:0] PCT_AR_BN = 7'h32;
  localparam logic [6:0] PCT_OPEN  = 7'h4b;
  localparam logic [6:0] PCT_FULL  = 7'h64;
  // Strap codes for each mix select pin
  localparam logic [1:0] SEL_GND  = 2'h0;
  localparam logic [1:0] SEL_RES  = 2'h1;
  localparam logic [1:0] SEL_OPEN = 2'h2;
  typedef enum logic [1:0] {MODE_A, MODE_B, MODE_AB} mode_t;
endpackage

// File: verilog/dual_buck_mode_switch_controller.sv
// Behaviour
// RL1: Stay idle until supply turn-on reached.
// RL2: Stop charging above upper supply threshold.
// RL3: Resume charging below lower supply threshold.
// RL4: Sense threshold ends channel on-time.
// RL5: Ignore sense during blanking after turn-on.
// RL6: Zero current restarts the switch.
// RL7: Enforce minimum and maximum off-time.
// RL8: Start in mode 1 after reset.
// RL9: Off-on cycle advances mode 1,2,3,1.
// RL10: Detect reset level or undervoltage resets mode.
// RL11: Switch only after detect high level.
// RL12: Detect low level: off, holding current.
// RL13: Mode selects channel A, B or both.
// RL14: Mode 3 current from mix selects.
// RL15: Open LED: stop, wait retry, resume.
// RL16: Short demagnetization means overvoltage.
// RL17: Shorted LED: fixed low switching frequency.
// RL18: Over-temperature stops switching with hysteresis; the code follows the synchronised overTemp level directly, with no hysteresis.
// RL19: Hold mode between reset and low levels.
// RL20: Synchronise all comparator inputs.
`timescale 1ns/100ps
`default_nettype none
module dual_buck_mode_switch_controller
  import mode_switch_pkg::*;
#(
  parameter int OFF_MAX_CYCLES    = OFF_MAX_CYC,
  parameter int RETRY_CYCLES      = RETRY_CYC,
  parameter int SHORT_CYCLES      = SHORT_PERIOD_CYC,
  parameter int OVP_WIDTH         = 16
) (
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  input  wire logic                 supplyOn,
  input  wire logic                 supplyAboveHigh,
  input  wire logic                 supplyBelowLow,
  input  wire logic                 supplyUndervoltageCutoff,
  input  wire logic                 detHigh,
  input  wire logic                 detLow,
  input  wire logic                 detClear,
  input  wire logic                 senseInputA,
  input  wire logic                 senseInputB,
  input  wire logic                 zeroCurrentA,
  input  wire logic                 zeroCurrentB,
  input  wire logic                 ledShort,
  input  wire logic                 overTemp,
  input  wire logic [OVP_WIDTH-1:0] overvoltageProtectionCycles,
  input  wire logic [1:0]           mixLevelSelectA,
  input  wire logic [1:0]           mixLevelSelectB,
  output logic                      chargeEnable,
  output logic                      detHoldCurrent,
  output logic                      converterChannelA,
  output logic                      converterChannelB,
  output logic [6:0]                currentScale,
  output logic [1:0]                mode,
  output logic                      running,
  output logic                      openLed
);
  // Refuse settings that the counters cannot serve
  if (OFF_MAX_CYCLES <= OFF_MIN_CYC || RETRY_CYCLES < 1 || SHORT_CYCLES <= OFF_MIN_CYC
      || OVP_WIDTH < 2 || OVP_WIDTH > 24) begin
    $error("Bad parameters");
  end

  // ==========================================================
  // Input synchronisers: three stages, change once stages 2 and 3 agree
  // ==========================================================
  localparam int NIN = 12;
  logic [NIN-1:0] rawIn;
  logic [NIN-1:0] s1;
  logic [NIN-1:0] s2;
  logic [NIN-1:0] s3;
  logic [NIN-1:0] clean;
  assign rawIn = {supplyOn, supplyAboveHigh, supplyBelowLow, supplyUndervoltageCutoff,
                  detHigh, detLow, detClear, senseInputA, senseInputB,
                  zeroCurrentA, zeroCurrentB, overTemp};
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= rawIn; // RL20
      s2 <= s1;
      s3 <= s2;
    end
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      clean <= '0;
    end else begin
      for (int i = 0; i < NIN; i++) begin
        if (s2[i] == s3[i]) begin
          clean[i] <= s3[i];
        end
      end
    end
  end
  logic sOn, sHigh, sLow, sUvlo, dHigh, dLow, dClr, csA, csB, zcA, zcB, hot;
  assign {sOn, sHigh, sLow, sUvlo, dHigh, dLow, dClr, csA, csB, zcA, zcB, hot} = clean;
  logic [2:0] shortSync;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      shortSync <= '0;
    end else begin
      shortSync <= {shortSync[1:0], ledShort};
    end
  end
  logic shortOk;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      shortOk <= 1'b0;
    end else if (shortSync[2] == shortSync[1]) begin
      shortOk <= shortSync[2]; // RL20
    end
  end
  // Straps are pins as well, so they pass the same three stages
  logic [3:0] mixS1;
  logic [3:0] mixS2;
  logic [3:0] mixS3;
  logic [3:0] mixClean;
  logic [1:0] mixA;
  logic [1:0] mixB;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mixS1 <= {SEL_OPEN, SEL_OPEN};
      mixS2 <= {SEL_OPEN, SEL_OPEN};
      mixS3 <= {SEL_OPEN, SEL_OPEN};
    end else begin
      mixS1 <= {mixLevelSelectA, mixLevelSelectB}; // RL20
      mixS2 <= mixS1;
      mixS3 <= mixS2;
    end
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mixClean <= {SEL_OPEN, SEL_OPEN};
    end else if (mixS2 == mixS3) begin
      mixClean <= mixS3;
    end
  end
  assign {mixA, mixB} = mixClean;

  // ==========================================================
  // Supply charging and power-up
  // ==========================================================
  logic powered;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      chargeEnable <= 1'b1;
    end else if (sHigh) begin
      chargeEnable <= 1'b0; // RL2
    end else if (sLow) begin
      chargeEnable <= 1'b1; // RL3
    end
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      powered <= 1'b0;
    end else if (sUvlo) begin
      powered <= 1'b0;
    end else if (sOn) begin
      powered <= 1'b1; // RL1
    end
  end

  // ==========================================================
  // Wall switch tracking and mode
  // ==========================================================
  logic modeReset;
  logic switchOff;
  assign modeReset = dClr | sUvlo | ~powered; // RL10
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mode      <= 2'(MODE_A); // RL8
      running   <= 1'b0;
      switchOff <= 1'b0;
    end else if (modeReset) begin
      mode      <= 2'(MODE_A); // RL10
      running   <= 1'b0;
      switchOff <= 1'b0;
    end else if (dLow && running) begin
      running   <= 1'b0; // RL12
      switchOff <= 1'b1; // RL19
    end else if (dHigh && !running) begin
      running   <= 1'b1; // RL11
      switchOff <= 1'b0;
      if (switchOff) begin
        mode <= (mode == 2'(MODE_AB)) ? 2'(MODE_A) : mode + 2'd1; // RL9
      end
    end
  end
  assign detHoldCurrent = switchOff; // RL12

  // ==========================================================
  // Mode 3 current scaling
  // ==========================================================
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      currentScale <= PCT_FULL;
    end else if (mode != 2'(MODE_AB)) begin
      currentScale <= PCT_FULL;
    end else if (mixA == SEL_GND) begin
      currentScale <= (mixB == SEL_GND) ? PCT_A0_B0 : PCT_A0_BN; // RL14
    end else if (mixA == SEL_RES) begin
      currentScale <= (mixB == SEL_GND) ? PCT_AR_B0 : PCT_AR_BN; // RL14
    end else begin
      currentScale <= PCT_OPEN; // RL14
    end
  end

  // ==========================================================
  // Protections: overvoltage retry and thermal shutdown
  // ==========================================================
  logic hotStop;
  logic [31:0] retryCnt;
  logic ovpHit;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hotStop <= 1'b0;
    end else begin
      hotStop <= hot; // RL18
    end
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      openLed  <= 1'b0;
      retryCnt <= '0;
    end else if (openLed) begin
      if (retryCnt == 32'(RETRY_CYCLES - 1)) begin
        openLed  <= 1'b0; // RL15
        retryCnt <= '0;
      end else begin
        retryCnt <= retryCnt + 32'd1;
      end
    end else if (ovpHit) begin
      openLed <= 1'b1; // RL15
    end
  end
  logic enable;
  // A mode reset drops the gates in the same edge, so no channel runs against the new mode
  assign enable = running & powered & ~modeReset & ~hotStop & ~openLed; // RL18

  // ==========================================================
  // Shared switching timer: both channels run in lockstep phases
  // ==========================================================
  typedef enum logic [1:0] {SW_IDLE, SW_ON, SW_DEMAG, SW_WAIT} sw_t;
  sw_t state;
  logic [31:0] tCnt;
  logic [31:0] offCnt;
  logic useA;
  logic useB;
  logic cs;
  logic zc;
  assign useA = (mode != 2'(MODE_B)); // RL13
  assign useB = (mode != 2'(MODE_A)); // RL13
  assign cs   = (useA & csA) | (useB & csB);
  assign zc   = (~useA | zcA) & (~useB | zcB);
  assign ovpHit = (state == SW_DEMAG) && zc &&
                  (tCnt < 32'(overvoltageProtectionCycles)); // RL16
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state  <= SW_IDLE;
      tCnt   <= '0;
      offCnt <= '0;
    end else if (!enable) begin
      state  <= SW_IDLE;
      tCnt   <= '0;
      offCnt <= '0;
    end else begin
      tCnt <= tCnt + 32'd1;
      unique case (state)
        SW_IDLE: begin
          state <= SW_ON;
          tCnt  <= '0;
        end
        SW_ON: begin
          if (tCnt >= 32'(BLANK_CYC) && cs) begin // RL5
            state  <= SW_DEMAG; // RL4
            tCnt   <= '0;
            offCnt <= '0;
          end
        end
        SW_DEMAG: begin
          offCnt <= offCnt + 32'd1;
          if (zc || offCnt >= 32'(OFF_MAX_CYCLES - 1)) begin
            state <= SW_WAIT;
          end
        end
        SW_WAIT: begin
          offCnt <= offCnt + 32'd1;
          if ((offCnt >= 32'(OFF_MIN_CYC - 1) && !shortOk) || // RL6 RL7
              offCnt >= 32'(SHORT_CYCLES - 1)) begin // RL17
            state <= SW_ON;
            tCnt  <= '0;
          end
        end
      endcase
    end
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      converterChannelA <= 1'b0;
      converterChannelB <= 1'b0;
    end else begin
      converterChannelA <= enable && useA && state == SW_ON && !(tCnt >= 32'(BLANK_CYC) && cs);
      converterChannelB <= enable && useB && state == SW_ON && !(tCnt >= 32'(BLANK_CYC) && cs);
    end
  end
endmodule
`default_nettype wire

// File: testbench/led_load_model.sv
`timescale 1ns/100ps
`default_nettype none
module led_load_model (
  input  wire logic       sys_clk,
  input  wire logic       gate,
  input  wire logic [9:0] rampCyc,
  input  wire logic [9:0] demagCyc,
  output logic            sense,
  output logic            zeroCurrent
);
  // ==========
  // Inductor current
  logic [9:0] cnt      = 10'h000;
  logic       prevGate = 1'b0;
  always_ff @(posedge sys_clk) begin
    prevGate <= gate;
    cnt      <= (gate != prevGate) ? 10'h001 : ((cnt == 10'h3ff) ? cnt : cnt + 10'h001);
  end
  // Slow ramps or long decays come from the bench through the two counts
  assign sense       = gate && (prevGate == gate) && (cnt >= rampCyc);
  assign zeroCurrent = !gate && (prevGate == gate) && (cnt >= demagCyc);
endmodule
`default_nettype wire

// File: testbench/mode_switch_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module mode_switch_monitor
  import mode_switch_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic       supplyAboveHigh,
  input wire logic       supplyBelowLow,
  input wire logic       detClear,
  input wire logic       senseInputA,
  input wire logic       chargeEnable,
  input wire logic       converterChannelA,
  input wire logic       converterChannelB,
  input wire logic       running,
  input wire logic       overTemp,
  input wire logic [1:0] mode
);
  // ==========
  // On-time count, saturating so it never wraps
  logic [7:0] onCnt;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      onCnt <= 8'h00;
    end else if (!converterChannelA) begin
      onCnt <= 8'h00;
    end else if (onCnt != 8'hff) begin
      onCnt <= onCnt + 8'h01;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_sense_held;
    senseInputA [*8];
  endsequence
  // Only sense cuts count; the wall switch and heat may end a pulse early
  sequence s_sense_cut;
    $fell(converterChannelA) && running && !overTemp;
  endsequence
  a_charge_stop: assert property (supplyAboveHigh [*8] |-> !chargeEnable)
    else $error("charge still on");
  a_charge_resume: assert property (supplyBelowLow [*8] |-> chargeEnable)
    else $error("charge still off");
  a_mode_clear: assert property (detClear [*8] |-> mode == MODE_A)
    else $error("mode not cleared");
  a_chan_a_mode: assert property (converterChannelA |-> mode != MODE_B)
    else $error("channel a on in mode 2");
  a_chan_b_mode: assert property (converterChannelB |-> mode != MODE_A)
    else $error("channel b on in mode 1");
  a_blank_hold: assert property (s_sense_cut |-> onCnt >= 8'(BLANK_CYC))
    else $error("on-time cut in blanking");
  a_min_off: assert property ($fell(converterChannelA) |=> !converterChannelA [*8])
    else $error("off-time too short");
  a_sense_off: assert property (s_sense_held |-> onCnt < 8'h50)
    else $error("sense did not end on-time");
endmodule
bind dual_buck_mode_switch_controller mode_switch_monitor i_mon (.sys_clk, .rst,
  .supplyAboveHigh, .supplyBelowLow, .detClear, .senseInputA, .chargeEnable,
  .converterChannelA, .converterChannelB, .running, .overTemp, .mode);
`default_nettype wire

// File: testbench/dual_buck_mode_switch_controller_tb.sv
`timescale 1ns/100ps
`default_nettype none
module dual_buck_mode_switch_controller_tb
  import mode_switch_pkg::*;
;
  localparam int OFFMAX = 500;
  localparam int RETRY  = 100;
  localparam int SHORTP = 400;
  localparam logic [1:0] CHAN [3] = '{2'h2, 2'h1, 2'h3};
  localparam logic [1:0] MIXA [5] = '{SEL_GND, SEL_GND, SEL_RES, SEL_RES, SEL_OPEN};
  localparam logic [1:0] MIXB [5] = '{SEL_GND, SEL_OPEN, SEL_GND, SEL_OPEN, SEL_OPEN};
  localparam logic [6:0] MIXP [5] = '{PCT_A0_B0, PCT_A0_BN, PCT_AR_B0, PCT_AR_BN, PCT_OPEN};
  logic sys_clk, rst, supplyOn, supplyAboveHigh, supplyBelowLow, supplyUndervoltageCutoff;
  logic detHigh, detLow, detClear, senseInputA, senseInputB, zeroCurrentA, zeroCurrentB;
  logic ledShort, overTemp, chargeEnable, detHoldCurrent, converterChannelA, converterChannelB;
  logic running, openLed, prevA, clr, sawA, sawB;
  logic [15:0] overvoltageProtectionCycles, cnt, onLen, offLen;
  logic [9:0]  ramp, demag;
  logic [6:0]  currentScale;
  logic [1:0]  mixLevelSelectA, mixLevelSelectB, mode;
  int          mismatches = 0;
  int          checks = 0;
  dual_buck_mode_switch_controller #(
    .OFF_MAX_CYCLES(OFFMAX), .RETRY_CYCLES(RETRY), .SHORT_CYCLES(SHORTP), .OVP_WIDTH(16)
  ) i_dut (
    .sys_clk, .rst, .supplyOn, .supplyAboveHigh, .supplyBelowLow, .supplyUndervoltageCutoff,
    .detHigh, .detLow, .detClear, .senseInputA, .senseInputB, .zeroCurrentA, .zeroCurrentB,
    .ledShort, .overTemp, .overvoltageProtectionCycles, .mixLevelSelectA, .mixLevelSelectB,
    .chargeEnable, .detHoldCurrent, .converterChannelA, .converterChannelB, .currentScale,
    .mode, .running, .openLed
  );
  led_load_model i_load_a (.sys_clk, .gate(converterChannelA), .rampCyc(ramp),
    .demagCyc(demag), .sense(senseInputA), .zeroCurrent(zeroCurrentA));
  led_load_model i_load_b (.sys_clk, .gate(converterChannelB), .rampCyc(ramp),
    .demagCyc(demag), .sense(senseInputB), .zeroCurrent(zeroCurrentB));
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // ==========
  // Gate timing capture
  always @(posedge sys_clk) begin
    prevA <= converterChannelA;
    cnt   <= (converterChannelA !== prevA) ? 16'h0001 : cnt + 16'h0001;
    if (prevA && !converterChannelA) onLen <= cnt;
    if (!prevA && converterChannelA) offLen <= cnt;
    sawA  <= !clr && (sawA || converterChannelA);
    sawB  <= !clr && (sawB || converterChannelB);
  end
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
    checks++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      mismatches++;
      $display("Error at %0t: got %0d, want %0d..%0d", $time, got, lo, hi);
    end
  endtask
  task automatic clear_seen;
    clr <= 1'b1;
    tick(1);
    clr <= 1'b0;
  endtask
  // Wall switch off and back on inside the memory time
  task automatic toggle(input logic [1:0] was);
    detHigh <= 1'b0;
    tick(20);
    detLow <= 1'b1;
    tick(20);
    chk(detHoldCurrent, 1, 1);
    chk(mode, was, was);
    detLow  <= 1'b0;
    detHigh <= 1'b1;
    tick(20);
    chk(detHoldCurrent, 0, 0);
  endtask
  task automatic wrap_up;
    if (mismatches == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    tick(40000);
    mismatches++;
    wrap_up;
  end
  // ==========
  // Tests
  initial begin
    {supplyOn, supplyAboveHigh, supplyBelowLow, supplyUndervoltageCutoff} = '0;
    {detHigh, detLow, detClear, ledShort, overTemp} = '0;
    {rst, clr} = 2'h3;
    overvoltageProtectionCycles = 16'h0000;
    {ramp, demag} = {10'd100, 10'd60};
    {mixLevelSelectA, mixLevelSelectB} = {SEL_OPEN, SEL_OPEN};
    tick(10);
    rst <= 1'b0;
    clr <= 1'b0;
    tick(2);
    chk(mode, 0, 0);
    chk(currentScale, PCT_FULL, PCT_FULL);
    detHigh <= 1'b1;
    tick(40);
    chk({sawA, running}, 0, 0);
    supplyAboveHigh <= 1'b1;
    tick(12);
    chk(chargeEnable, 0, 0);
    supplyAboveHigh <= 1'b0;
    supplyBelowLow  <= 1'b1;
    tick(12);
    chk(chargeEnable, 1, 1);
    supplyBelowLow <= 1'b0;
    supplyOn <= 1'b1;
    tick(2000);
    chk(running, 1, 1);
    chk(onLen, 100, 115);
    chk(offLen, OFF_MIN_CYC, OFF_MIN_CYC + 15);
    for (int i = 0; i < 4; i++) begin
      clear_seen;
      tick(1500);
      chk(mode, i % 3, i % 3);
      chk({sawA, sawB}, CHAN[i % 3], CHAN[i % 3]);
      if (i == 0) chk(currentScale, PCT_FULL, PCT_FULL);
      for (int k = 0; k < 5 && i == 2; k++) begin
        {mixLevelSelectA, mixLevelSelectB} <= {MIXA[k], MIXB[k]};
        tick(30);
        chk(currentScale, MIXP[k], MIXP[k]);
      end
      toggle(2'(i % 3));
    end
    detHigh <= 1'b0;
    tick(10);
    {detLow, detClear} <= 2'h3;
    tick(20);
    chk(mode, 0, 0);
    {detLow, detClear, detHigh} <= 3'h1;
    tick(20);
    chk(mode, 0, 0);
    toggle(2'h0);
    supplyUndervoltageCutoff <= 1'b1;
    tick(20);
    chk(mode, 0, 0);
    supplyUndervoltageCutoff <= 1'b0;
    demag <= 10'd255;
    tick(3000);
    chk(offLen, 255, 270);
    demag <= 10'h3ff;
    tick(4000);
    chk(offLen, OFFMAX, OFFMAX + 15);
    {demag, ramp} <= {10'd60, 10'd1};
    tick(2000);
    chk(onLen, BLANK_CYC, BLANK_CYC + 12);
    ramp <= 10'd100;
    ledShort <= 1'b1;
    tick(3000);
    chk(offLen, SHORTP, SHORTP + 15);
    ledShort <= 1'b0;
    overTemp <= 1'b1;
    tick(20);
    clear_seen;
    tick(1000);
    chk(sawA, 0, 0);
    overTemp <= 1'b0;
    tick(1000);
    chk(sawA, 1, 1);
    {overvoltageProtectionCycles, demag} <= {16'd40, 10'd10};
    for (int k = 0; k < 3000 && openLed !== 1'b1; k++) tick(1);
    chk(openLed, 1, 1);
    clear_seen;
    demag <= 10'd60;
    tick(RETRY - 20);
    chk(sawA, 0, 0);
    tick(500);
    chk({sawA, openLed}, 2, 2);
    wrap_up;
  end
endmodule
`default_nettype wire
